// ===== hdl/rpps_pkg.sv
/*
 * Constants, register map and state types for the dual reverse/under
 * power protection stage.
 * Assumes a 250 MHz pclk and a measurement front end that presents
 * signed three-phase active power in watts, synchronous to pclk.
 */
package rpps_pkg;

   ////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 250_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   ////////////////////////////////////////////////////////////////////
   // Widths and scaling
   localparam int NUM_STAGES = 2;
   localparam int EVT_W = 4;
   localparam int INT_W = NUM_STAGES * EVT_W;
   localparam logic [16:0] SQRT3_Q16 = 17'h1bb68;
   localparam int SQRT3_FRAC = 16;
   localparam logic signed [47:0] PWR_SCALE = 48'sh0003e8;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic [11:0] PCT_STEP = 12'h064;

   ////////////////////////////////////////////////////////////////////
   // Setting limits and reset values (pick-up in 0.1 %Sn, delay 0.1 s)
   localparam logic signed [11:0] PICK_MAX = 12'sh7d0;
   localparam logic signed [11:0] PICK_MIN = 12'sh830;
   localparam logic [11:0] PICK_RST0 = 12'hfd8;
   localparam logic [11:0] PICK_RST1 = 12'hf38;
   localparam logic [11:0] DLY_MIN = 12'h003;
   localparam logic [11:0] DLY_MAX = 12'hbb8;
   localparam logic [11:0] DLY_RST = 12'h00a;
   localparam logic [3:0] EVT_EN_RST = 4'hf;
   localparam logic [15:0] VT_RST = 16'h2af8;
   localparam logic [11:0] CT_RST = 12'h064;
   localparam logic [7:0] INT_EN_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [11:0] OFF_VT = 12'h000;
   localparam logic [11:0] OFF_CT = 12'h004;
   localparam logic [11:0] OFF_SN = 12'h008;
   localparam logic [11:0] OFF_STG_BASE = 12'h010;
   localparam logic [11:0] OFF_STG_STRIDE = 12'h020;
   localparam logic [11:0] OFF_STG_PICK = 12'h000;
   localparam logic [11:0] OFF_STG_DLY = 12'h004;
   localparam logic [11:0] OFF_STG_EVT = 12'h008;
   localparam logic [11:0] OFF_STG_STATUS = 12'h00c;
   localparam logic [11:0] OFF_STG_TALLY = 12'h010;
   localparam logic [11:0] OFF_STG_FAULT = 12'h014;
   localparam logic [11:0] OFF_STG_CLR = 12'h018;
   localparam logic [11:0] OFF_INT_STATUS = 12'h050;
   localparam logic [11:0] OFF_INT_CLEAR = 12'h054;
   localparam logic [11:0] OFF_INT_ENABLE = 12'h058;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ST_START_BIT = 0;
   localparam int ST_TRIP_BIT = 1;
   localparam int ST_PCT_LSB = 8;
   localparam int TALLY_TRIP_LSB = 16;
   localparam int EV_S_ON = 0;
   localparam int EV_S_OFF = 1;
   localparam int EV_T_ON = 2;
   localparam int EV_T_OFF = 3;

   ////////////////////////////////////////////////////////////////////
   // State types
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } rpps_tick_t;

   typedef struct packed {
      logic [11:0] acc;
      logic [6:0] pct;
      logic trip;
   } rpps_tmr_t;

   typedef struct packed {
      logic [15:0] vt;
      logic [11:0] ct;
      logic [28:0] sn;
      logic [1:0][11:0] pick;
      logic [1:0][11:0] dly;
      logic [1:0][3:0] evt_en;
      logic [1:0] start;
      logic [1:0] trip_q;
      logic [1:0][15:0] s_tally;
      logic [1:0][15:0] t_tally;
      logic [1:0][31:0] fault;
      logic [7:0] int_st;
      logic [7:0] int_en;
      logic [31:0] rdata;
      logic slverr;
   } rpps_top_t;

endpackage

// ===== hdl/rpps_tick.sv
/*
 * Restartable divider giving a one-cycle tick every TICK_CYCLES clocks.
 * Assumes restart is held while the owning stage is idle, so the first
 * tick comes one full period after the stage picks up.
 */
`timescale 1ns/1ns
`default_nettype none

module rpps_tick
   import rpps_pkg::*;
#(
   parameter int TICK_CYCLES = rpps_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   output logic tick
);

   rpps_tick_t st_ff;
   rpps_tick_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (restart) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == 32'(TICK_CYCLES - 1)) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

endmodule

`default_nettype wire

// ===== hdl/rpps_timer.sv
/*
 * Definite-time delay of one stage with elapsed-delay percentage.
 * Assumes tick pulses every 0.1 s while start is high and delay is in
 * 0.1 s units, between 3 and 3000.
 */
`timescale 1ns/1ns
`default_nettype none

module rpps_timer
   import rpps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic tick,
   input wire logic [11:0] delay,
   output logic [6:0] elapsed_delay_percent,
   output logic trip
);

   rpps_tmr_t st_ff;
   rpps_tmr_t nxt_st;
   logic [11:0] sum;

   // Percent steps by Bresenham: each tick adds 100, each delay unit
   // worth of remainder is one percent, at most one step per cycle.
   always_comb begin
      nxt_st = st_ff;
      sum = st_ff.acc;
      if (!start) begin
         nxt_st = '0; // see R10
      end else if (!st_ff.trip) begin
         sum = st_ff.acc + (tick ? PCT_STEP : 12'h000);
         if (sum >= delay) begin
            sum = sum - delay;
            nxt_st.pct = st_ff.pct + 7'h01; // see R9
         end
         nxt_st.acc = sum;
         if (nxt_st.pct == PCT_FULL) begin
            nxt_st.trip = 1'b1; // see R2
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign elapsed_delay_percent = st_ff.pct;
   assign trip = st_ff.trip;

endmodule

`default_nettype wire

// ===== hdl/rpps_top.sv
/*
 * Dual reverse/under power protection stage with APB register file,
 * start and trip tallies, fault capture and a level interrupt.
 * Assumes active_power is signed watts synchronous to pclk, and an APB
 * master that keeps the usual setup/access ordering.
 */
// Functional notes
// R1: Start asserts while active power is below the stage pick-up level.
// R2: Trip asserts once start has stayed for the whole operational delay.
// R3: Pick-up is signed, -200..+200 %Sn, defaults -4.0 and -20.0.
// R4: Negative pick-up gives reverse power, positive gives underpower.
// R5: Nominal apparent power is VT primary times CT primary times root 3.
// R6: Two identical stages, each with its own settings.
// R7: Operational delay settable 0.3 to 300.0 s, default 1.0 s.
// R8: Count starts and trips, record extreme power during the fault.
// R9: Elapsed delay reported in percent, 100 reached together with trip.
// R10: Power back above pick-up drops start, clears timer and trip.
`timescale 1ns/1ns
`default_nettype none

module rpps_top
   import rpps_pkg::*;
#(
   parameter int TICK_CYCLES = rpps_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] active_power,
   output logic [rpps_pkg::NUM_STAGES-1:0] stage_start,
   output logic [rpps_pkg::NUM_STAGES-1:0] stage_trip,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   rpps_top_t st_ff;
   rpps_top_t nxt_st;

   logic [44:0] sn_full;
   logic signed [47:0] pwr_scaled;
   logic signed [47:0] level [NUM_STAGES];
   logic [NUM_STAGES-1:0] below;
   logic [NUM_STAGES-1:0] tick;
   logic [NUM_STAGES-1:0] trip_w;
   logic [6:0] pct_w [NUM_STAGES];
   logic apb_setup;
   logic apb_write;

   ////////////////////////////////////////////////////////////////////
   // Nominal apparent power in VA, root 3 in Q16

   assign sn_full = 45'(st_ff.vt * st_ff.ct * SQRT3_Q16); // see R5

   ////////////////////////////////////////////////////////////////////
   // Comparison: power*1000 < pick(0.1 %Sn) * Sn, no divider needed

   assign pwr_scaled = $signed({{16{active_power[31]}}, active_power})
      * PWR_SCALE;

   // One signed compare serves both reverse and underpower settings
   generate
      for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
         assign level[g] = $signed({{36{st_ff.pick[g][11]}},
            st_ff.pick[g]}) * $signed({19'h00000, st_ff.sn});
         assign below[g] = pwr_scaled < level[g]; // see R1, R4

         rpps_tick #(
            .TICK_CYCLES(TICK_CYCLES)
         ) u_tick (
            .pclk(pclk),
            .presetn(presetn),
            .restart(~st_ff.start[g]),
            .tick(tick[g])
         );

         rpps_timer u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .start(st_ff.start[g]),
            .tick(tick[g]),
            .delay(st_ff.dly[g]),
            .elapsed_delay_percent(pct_w[g]),
            .trip(trip_w[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // APB phases

   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [11:0] off;
      logic hit;
      logic [3:0] ev;
      logic [31:0] rd;
      logic err;
      logic signed [31:0] wval;
      logic [1:0] clr;

      off = '0;
      hit = 1'b0;
      ev = '0;
      rd = '0;
      err = 1'b1;
      wval = $signed(pwdata);
      clr = '0;
      nxt_st = st_ff;

      nxt_st.sn = sn_full[SQRT3_FRAC +: 29];

      ////////////////////////////////////////////////////////////////
      // Register writes, taken in the access phase
      if (apb_write && paddr[1:0] == 2'b00) begin
         if (paddr == OFF_VT) begin
            nxt_st.vt = pwdata[15:0];
         end
         if (paddr == OFF_CT) begin
            nxt_st.ct = pwdata[11:0];
         end
         if (paddr == OFF_INT_ENABLE) begin
            nxt_st.int_en = pwdata[7:0];
         end
         if (paddr == OFF_INT_CLEAR) begin
            nxt_st.int_st = st_ff.int_st & ~pwdata[7:0];
         end
         for (int n = 0; n < NUM_STAGES; n++) begin
            off = 12'(paddr - OFF_STG_BASE - 12'(n) * OFF_STG_STRIDE);
            hit = paddr >= 12'(OFF_STG_BASE + 12'(n) * OFF_STG_STRIDE)
               && off <= OFF_STG_CLR;
            if (hit && off == OFF_STG_PICK) begin
               // Out of range settings are clamped to the limits
               if (wval > 32'(PICK_MAX)) begin
                  nxt_st.pick[n] = PICK_MAX; // see R3
               end else if (wval < 32'(PICK_MIN)) begin
                  nxt_st.pick[n] = PICK_MIN; // see R3
               end else begin
                  nxt_st.pick[n] = pwdata[11:0];
               end
            end
            if (hit && off == OFF_STG_DLY) begin
               if (pwdata < 32'(DLY_MIN)) begin
                  nxt_st.dly[n] = DLY_MIN; // see R7
               end else if (pwdata > 32'(DLY_MAX)) begin
                  nxt_st.dly[n] = DLY_MAX; // see R7
               end else begin
                  nxt_st.dly[n] = pwdata[11:0];
               end
            end
            if (hit && off == OFF_STG_EVT) begin
               nxt_st.evt_en[n] = pwdata[3:0];
            end
            if (hit && off == OFF_STG_CLR) begin
               clr[n] = 1'b1;
            end
         end
      end

      ////////////////////////////////////////////////////////////////
      // Per-stage start, tallies, fault value and events
      for (int n = 0; n < NUM_STAGES; n++) begin // see R6
         nxt_st.start[n] = below[n]; // see R1, R10
         nxt_st.trip_q[n] = trip_w[n];
         if (clr[n]) begin
            nxt_st.s_tally[n] = '0;
            nxt_st.t_tally[n] = '0;
         end
         // Increments after the clear so a coincident event counts
         if (below[n] && !st_ff.start[n]) begin
            nxt_st.s_tally[n] = nxt_st.s_tally[n] + 16'h0001; // see R8
            nxt_st.fault[n] = active_power; // see R8
         end else if (below[n] && st_ff.start[n]
            && $signed(active_power) < $signed(st_ff.fault[n])) begin
            nxt_st.fault[n] = active_power; // see R8
         end
         if (trip_w[n] && !st_ff.trip_q[n]) begin
            nxt_st.t_tally[n] = nxt_st.t_tally[n] + 16'h0001; // see R8
         end
         ev = '0;
         ev[EV_S_ON] = below[n] & ~st_ff.start[n];
         ev[EV_S_OFF] = ~below[n] & st_ff.start[n];
         ev[EV_T_ON] = trip_w[n] & ~st_ff.trip_q[n];
         ev[EV_T_OFF] = ~trip_w[n] & st_ff.trip_q[n];
         // Set after clear: an event in the clear cycle stays pending
         nxt_st.int_st[n*EVT_W +: EVT_W] =
            nxt_st.int_st[n*EVT_W +: EVT_W] | (ev & st_ff.evt_en[n]);
      end

      ////////////////////////////////////////////////////////////////
      // Read data captured in the setup phase
      if (paddr[1:0] == 2'b00) begin
         if (paddr == OFF_VT) begin
            rd = {16'h0000, st_ff.vt};
            err = 1'b0;
         end
         if (paddr == OFF_CT) begin
            rd = {20'h00000, st_ff.ct};
            err = 1'b0;
         end
         if (paddr == OFF_SN) begin
            rd = {3'h0, st_ff.sn}; // see R5
            err = 1'b0;
         end
         if (paddr == OFF_INT_STATUS) begin
            rd = {24'h000000, st_ff.int_st};
            err = 1'b0;
         end
         if (paddr == OFF_INT_CLEAR) begin
            err = 1'b0;
         end
         if (paddr == OFF_INT_ENABLE) begin
            rd = {24'h000000, st_ff.int_en};
            err = 1'b0;
         end
         for (int n = 0; n < NUM_STAGES; n++) begin
            off = 12'(paddr - OFF_STG_BASE - 12'(n) * OFF_STG_STRIDE);
            hit = paddr >= 12'(OFF_STG_BASE + 12'(n) * OFF_STG_STRIDE)
               && off <= OFF_STG_CLR;
            if (hit) begin
               err = 1'b0;
               if (off == OFF_STG_PICK) begin
                  rd = {{20{st_ff.pick[n][11]}}, st_ff.pick[n]};
               end
               if (off == OFF_STG_DLY) begin
                  rd = {20'h00000, st_ff.dly[n]};
               end
               if (off == OFF_STG_EVT) begin
                  rd = {28'h0000000, st_ff.evt_en[n]};
               end
               if (off == OFF_STG_STATUS) begin
                  rd[ST_START_BIT] = st_ff.start[n];
                  rd[ST_TRIP_BIT] = trip_w[n];
                  rd[ST_PCT_LSB +: 7] = pct_w[n]; // see R9
               end
               if (off == OFF_STG_TALLY) begin
                  rd[15:0] = st_ff.s_tally[n];
                  rd[TALLY_TRIP_LSB +: 16] = st_ff.t_tally[n];
               end
               if (off == OFF_STG_FAULT) begin
                  rd = st_ff.fault[n];
               end
            end
         end
      end
      if (apb_setup) begin
         nxt_st.rdata = pwrite ? 32'h00000000 : rd;
         nxt_st.slverr = err;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.vt <= VT_RST;
         st_ff.ct <= CT_RST;
         st_ff.pick[0] <= PICK_RST0; // see R3
         st_ff.pick[1] <= PICK_RST1; // see R3
         st_ff.dly[0] <= DLY_RST; // see R7
         st_ff.dly[1] <= DLY_RST; // see R7
         st_ff.evt_en[0] <= EVT_EN_RST;
         st_ff.evt_en[1] <= EVT_EN_RST;
         st_ff.int_en <= INT_EN_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = st_ff.rdata;
   assign pready = 1'b1;
   assign pslverr = st_ff.slverr & psel & penable;
   assign stage_start = st_ff.start;
   assign stage_trip = trip_w;
   assign irq = |(st_ff.int_st & st_ff.int_en);

endmodule

`default_nettype wire

// ===== verif/rpps_meter.sv
/*
 * Measurement front end model: presents signed three-phase active power.
 * Assumes the bench sets the wanted level; it reaches the pins one pclk
 * later, as a registered front end would deliver it.
 */
`timescale 1ns/1ns
`default_nettype none

module rpps_meter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] level,
   output logic [31:0] active_power
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_power <= '0;
      end else begin
         active_power <= level;
      end
   end
endmodule

`default_nettype wire

// ===== verif/rpps_checker.sv
/*
 * Concurrent checks on the ports of the dual power stage.
 * Assumes one pclk domain with asynchronous active-low presetn.
 */
`timescale 1ns/1ns
`default_nettype none

module rpps_checker
   import rpps_pkg::*;
#(
   parameter int TICK_CYCLES = rpps_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] active_power,
   input wire logic [rpps_pkg::NUM_STAGES-1:0] stage_start,
   input wire logic [rpps_pkg::NUM_STAGES-1:0] stage_trip,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////
   sequence s_pickup0;
      $rose(stage_start[0]);
   endsequence
   sequence s_no_trip0;
      !stage_trip[0] [*8];
   endsequence

   a_trip_not_early: assert property (s_pickup0 |-> s_no_trip0)
      else $error("trip rose too soon after start");
   a_trip_needs_start: assert property (stage_trip[0] |->
      stage_start[0] || $past(stage_start[0]))
      else $error("trip without start");
   a_trip_clear_s0: assert property ($fell(stage_start[0]) |=>
      !stage_trip[0])
      else $error("stage 0 trip kept after release");
   a_trip_clear_s1: assert property ($fell(stage_start[1]) |=>
      !stage_trip[1])
      else $error("stage 1 trip kept after release");
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   a_err_zero_data: assert property (pslverr |-> prdata == 32'h00000000)
      else $error("error read with data");
   a_irq_masked: assert property (psel && penable && pwrite &&
      paddr == OFF_INT_ENABLE && pwdata[7:0] == 8'h00 |-> ##[1:2] !irq)
      else $error("irq with all enables off");
   a_quiet_release: assert property ($rose(presetn) |->
      !irq && stage_trip == 2'b00)
      else $error("outputs active after reset");
endmodule

bind rpps_top rpps_checker #(.TICK_CYCLES(TICK_CYCLES)) rpps_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .active_power(active_power),
   .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));

`default_nettype wire

// ===== verif/tb.sv
/*
 * Self-checking bench of the dual power stage over APB.
 * Assumes a shortened tick divider of 100 pclk per 0.1 s.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module tb;
   import rpps_pkg::*;
   // Tick must outlast the up to 34 one-cycle percent steps
   localparam int TCK = 100;
   localparam logic [63:0] SN_W =
      (64'(VT_RST) * 64'(CT_RST) * 64'(SQRT3_Q16)) >> SQRT3_FRAC;
   localparam int SN = int'(SN_W);
   localparam int B0 = 40 * SN / 1000 + 1;
   localparam int B1 = 200 * SN / 1000 + 1;
   localparam logic [11:0] S0 = OFF_STG_BASE;
   localparam logic [11:0] S1 = OFF_STG_BASE + OFF_STG_STRIDE;
   typedef struct packed {
      logic [31:0] pwr;
      logic [1:0] st;
   } rpps_row_t;
   rpps_row_t rows [6] = '{'{32'(0), 2'b00}, '{32'(1 - B0), 2'b00},
      '{32'(-B0), 2'b01}, '{32'(1 - B1), 2'b01}, '{32'(-B1), 2'b11},
      '{32'(100000), 2'b00}};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, irq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, active_power, rd;
   logic [31:0] lvl = '0;
   logic [1:0] stage_start, stage_trip;
   logic er;
   int errors = 0, n_checks = 0, cycles = 0, cnt;

   always #2 pclk = ~pclk;

   rpps_meter rpps_meter_inst (.pclk(pclk), .presetn(presetn),
      .level(lvl), .active_power(active_power));
   rpps_top #(.TICK_CYCLES(TCK)) rpps_top_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .active_power(active_power),
      .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));

   ////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      `CHK(rd, exp)
   endtask

   task automatic waitn(input int n);
      repeat (n) @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      waitn(3);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         lvl <= rows[i].pwr;
         waitn(3);
         `CHK(stage_start, rows[i].st)
      end
      $display("threshold rows done");
      rchk(OFF_VT, 32'(VT_RST));
      rchk(OFF_SN, 32'(SN));
      rchk(S0 + OFF_STG_PICK, 32'hffffffd8);
      rchk(S1 + OFF_STG_PICK, 32'hffffff38);
      rchk(S0 + OFF_STG_DLY, 32'(DLY_RST));
      rchk(S0 + OFF_STG_EVT, 32'h0000000f);
      rchk(OFF_INT_ENABLE, 32'h00000000);
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, S0 + OFF_STG_PICK, 32'(-3000));
      rchk(S0 + OFF_STG_PICK, 32'hfffff830);
      apb(1'b1, S0 + OFF_STG_PICK, 32'hffffffd8);
      apb(1'b1, S1 + OFF_STG_DLY, 32'(5000));
      rchk(S1 + OFF_STG_DLY, 32'(DLY_MAX));
      apb(1'b1, S0 + OFF_STG_DLY, 32'(1));
      rchk(S0 + OFF_STG_DLY, 32'(DLY_MIN));
      $display("register test done");
      apb(1'b1, S0 + OFF_STG_CLR, 32'h1);
      apb(1'b1, OFF_INT_CLEAR, 32'hff);
      @(posedge pclk);
      lvl <= 32'(-100000);
      cnt = 0;
      while (stage_trip[0] !== 1'b1 && cnt < 400) begin
         @(posedge pclk);
         cnt++;
      end
      `CHK(cnt >= 3 * TCK + 2 && cnt <= 3 * TCK + 40, 1'b1)
      rchk(S0 + OFF_STG_STATUS, 32'h00006403);
      rchk(S0 + OFF_STG_TALLY, 32'h00010001);
      rchk(S0 + OFF_STG_FAULT, 32'(-100000));
      rchk(OFF_INT_STATUS, 32'h00000005);
      apb(1'b1, OFF_INT_ENABLE, 32'h01);
      waitn(1);
      `CHK(irq, 1'b1)
      apb(1'b1, OFF_INT_ENABLE, 32'h00);
      waitn(1);
      `CHK(irq, 1'b0)
      lvl <= 32'(0);
      waitn(4);
      `CHK(stage_trip, 2'b00)
      rchk(S0 + OFF_STG_STATUS, 32'h00000000);
      rchk(OFF_INT_STATUS, 32'h0000000f);
      apb(1'b1, OFF_INT_ENABLE, 32'h08);
      apb(1'b1, OFF_INT_CLEAR, 32'h0f);
      waitn(1);
      `CHK(irq, 1'b0)
      rchk(OFF_INT_STATUS, 32'h00000000);
      $display("trip test done");
      lvl <= 32'(-100000);
      waitn(15);
      lvl <= 32'(0);
      waitn(40);
      `CHK(stage_trip, 2'b00)
      rchk(S0 + OFF_STG_TALLY, 32'h00010002);
      apb(1'b1, S0 + OFF_STG_PICK, 32'(100));
      lvl <= 32'(100000);
      waitn(3);
      `CHK(stage_start, 2'b01)
      lvl <= 32'(200000);
      waitn(3);
      `CHK(stage_start, 2'b00)
      $display("abort and underpower test done");
      lvl <= 32'(-B1);
      presetn <= 1'b0;
      waitn(3);
      `CHK({irq, stage_start, stage_trip}, 5'h00)
      presetn <= 1'b1;
      rchk(S0 + OFF_STG_PICK, 32'hffffffd8);
      `CHK(stage_start, 2'b11)
      $display("reset test done");
      complete_run();
   end
endmodule

`default_nettype wire
